// ==== hw/ssbc_pkg.sv ====
// ssbc_pkg: shared constants and carriers for the bus sequencer
// assumes: byte-addressed host memory, 32-bit apb data
package ssbc_pkg;
  // ----------------------------------------
  // opcodes, word 0 bits 31:28
  // ----------------------------------------
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_MOVE = 4'h1;
  localparam logic [3:0] OP_CHAINED = 4'h2; // chained_block_move
  localparam logic [3:0] OP_MEMMOVE = 4'h3;
  localparam logic [3:0] OP_JUMP = 4'h4;
  localparam logic [3:0] OP_CALL = 4'h5;
  localparam logic [3:0] OP_RETURN = 4'h6;
  localparam logic [3:0] OP_INT = 4'h7;
  localparam logic [3:0] OP_NONHALT = 4'h8; // nonhalting_interrupt_instr
  localparam logic [3:0] OP_WAIT_DISC = 4'h9;
  localparam logic [3:0] OP_SET = 4'hA;
  localparam logic [3:0] OP_CLEAR = 4'hB;
  localparam logic [3:0] OP_DISCONNECT = 4'hC;
  localparam logic [3:0] OP_REGMOVE = 4'hD;
  // ----------------------------------------
  // word 0 field positions; F_OFS_HI is in word 1
  // ----------------------------------------
  localparam int F_OP_HI = 31;
  localparam int F_OP_LO = 28;
  localparam int F_REL = 27; // relative branch, or pointer_indirect_qualifier on moves
  localparam int F_TABLE = 26;
  localparam int F_TARGET = 25;
  localparam int F_WHEN = 24;
  localparam int F_NOT = 23;
  localparam int F_PH_EN = 22;
  localparam int F_DATA_EN = 21;
  localparam int F_CARRY = 20;
  localparam int F_OR = 19;
  localparam int F_PH_HI = 18;
  localparam int F_PH_LO = 16;
  localparam int F_CNT_HI = 15;
  localparam int F_DATA_HI = 7;
  localparam int F_OFS_HI = 23;
  localparam int F_SB_ATN = 0;
  localparam int F_SB_ACK = 1;
  localparam int F_SB_CARRY = 2;
  localparam int F_RS_HI = 9;
  localparam int F_RS_LO = 8;
  localparam int F_RD_HI = 1;
  // ----------------------------------------
  // bus phases {msg, cd, io}
  // ----------------------------------------
  localparam logic [2:0] data_out_phase = 3'h0;
  localparam logic [2:0] data_in_phase = 3'h1;
  localparam logic [2:0] command_phase = 3'h2;
  localparam logic [2:0] status_phase = 3'h3;
  localparam logic [2:0] reserved_phase_a = 3'h4;
  localparam logic [2:0] reserved_phase_b = 3'h5;
  localparam logic [2:0] message_out_phase = 3'h6;
  localparam logic [2:0] message_in_phase = 3'h7;
  localparam int PH_IO = 0;
  // ----------------------------------------
  // apb map, reset values, steps
  // ----------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_IP = 8'h04;
  localparam logic [7:0] A_INTCODE = 8'h08;
  localparam logic [3:0] A_GP_PAGE = 4'h1; // 0x10..0x1c
  localparam int C_START = 0;
  localparam int C_IRQ_CLR = 1;
  localparam logic [31:0] IP_RST = 32'h0000_0000;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [31:0] PHASE_MISMATCH_CODE = 32'hFFFF_0001;
  localparam logic [1:0] GP_TABLE = 2'h0;
  localparam logic [1:0] GP_RET = 2'h3;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic bsy;
    logic req;
    logic ack;
    logic [2:0] phase;
    logic [7:0] data;
  } ssbc_bus_in_type;
  typedef struct packed {
    logic atn;
    logic ack;
    logic req;
    logic bsy;
    logic [2:0] phase;
    logic [7:0] data;
    logic atn_oe_n;
    logic ack_oe_n;
    logic req_oe_n;
    logic bsy_oe_n;
    logic phase_oe_n;
    logic data_oe_n;
  } ssbc_bus_out_type;
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [7:0] wdata;
  } ssbc_mem_req_type;
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } ssbc_mem_rsp_type;
endpackage : ssbc_pkg

// ==== hw/ssbc_sequencer.sv ====
// ssbc_sequencer: instruction fetch, decode and bus handshake engine
// assumes: memory answers each request with one ack pulse; apb on clk
`timescale 1ns/1ps
// Contract
// - taken call branches and saves return address
// - taken jump branches, return register untouched
// - return reloads pointer; one level only
// - halting interrupt flags host and stops
// - non-halting interrupt flags host, keeps running
// - immediate form compares latched phase
// - deferred form compares phase at next req
// - target moves drive the named phase
// - relative branch adds signed offset to pointer
// - wait idles until bus goes free
// - target disconnect releases the bus
// - set/clear touch only selected bits
// - memory move copies bytes, bus untouched
// - conditions may test the carry bit
// - not inverts; and/or combine tests
// - eight bus phases supported
// - table indirect fetches count and address
// - pointer indirect reads data address first
// - attention and acknowledge drive bus lines
// - target qualifier enters target mode
// - registers moved by register number
module ssbc_sequencer (
  input wire logic clk, // 10 mhz
  input wire logic rst, // async, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped
  output ssbc_pkg::ssbc_mem_req_type mem_o, // host memory request
  input wire ssbc_pkg::ssbc_mem_rsp_type mem_i, // host memory answer
  input wire ssbc_pkg::ssbc_bus_in_type bus_i, // bus pins in
  output ssbc_pkg::ssbc_bus_out_type bus_o, // bus pins out
  output logic host_irq // interrupt to host
);
  typedef enum logic [3:0] {
    ST_HALT, ST_F0, ST_F1, ST_F2, ST_EXEC, ST_DEFER, ST_TBL0, ST_TBL1,
    ST_PTR, ST_XPREP, ST_XSYNC, ST_XWR, ST_XDONE, ST_MMRD, ST_MMWR, ST_WDISC
  } ssbc_state_type;

  ssbc_state_type state_reg;
  ssbc_pkg::ssbc_bus_in_type s1_reg, s2_reg, s3_reg, bf_reg;
  logic req_prev_reg;
  logic [31:0] ip_reg, ir0_reg, ir1_reg, ir2_reg, intcode_reg, xaddr_reg, dst_reg;
  logic [31:0] maddr_reg;
  logic [31:0] gp_reg [4];
  logic [15:0] xcnt_reg;
  logic [7:0] byte_reg, first_byte_reg;
  logic [2:0] phase_lat_reg, phase_drv_reg;
  logic carry_reg, target_reg, atn_reg, ack_reg, req_reg, phase_oe_reg, data_oe_reg, irq_reg;
  logic req_rise, take_now, take_def, take, tgt, send, is_move, is_branch, defer_br;
  logic br_fire, irq_set, irq_clr, apb_wr, apb_hit, halt_now;
  logic [3:0] op;
  logic [2:0] ph;
  logic [31:0] dest, prdata_next;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // a level only counts once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      bf_reg <= '0;
      req_prev_reg <= 1'b0;
    end else begin
      s1_reg <= bus_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      bf_reg <= (s2_reg & s3_reg) | (bf_reg & (s2_reg | s3_reg));
      req_prev_reg <= bf_reg.req;
    end
  end

  // ----------------------------------------
  // condition evaluation
  // ----------------------------------------
  function automatic logic cond_eval(input logic [31:0] w, input logic [2:0] p_in, input logic [7:0] d_in,
                                     input logic cy);
    logic p, d, en, any_hit, all_hit;
    p = p_in == w[ssbc_pkg::F_PH_HI:ssbc_pkg::F_PH_LO];
    d = d_in == w[ssbc_pkg::F_DATA_HI:0];
    en = w[ssbc_pkg::F_PH_EN] | w[ssbc_pkg::F_DATA_EN] | w[ssbc_pkg::F_CARRY];
    any_hit = (w[ssbc_pkg::F_PH_EN] & p) | (w[ssbc_pkg::F_DATA_EN] & d) | (w[ssbc_pkg::F_CARRY] & cy);
    all_hit = (!w[ssbc_pkg::F_PH_EN] | p) & (!w[ssbc_pkg::F_DATA_EN] | d) & (!w[ssbc_pkg::F_CARRY] | cy);
    return (en ? (w[ssbc_pkg::F_OR] ? any_hit : all_hit) : 1'b1) ^ w[ssbc_pkg::F_NOT];
  endfunction : cond_eval

  // decode and branch selection
  assign op = ir0_reg[ssbc_pkg::F_OP_HI:ssbc_pkg::F_OP_LO];
  assign ph = ir0_reg[ssbc_pkg::F_PH_HI:ssbc_pkg::F_PH_LO];
  assign req_rise = bf_reg.req & !req_prev_reg;
  assign is_move = (op == ssbc_pkg::OP_MOVE) || (op == ssbc_pkg::OP_CHAINED);
  assign is_branch = (op == ssbc_pkg::OP_JUMP) || (op == ssbc_pkg::OP_CALL) || (op == ssbc_pkg::OP_RETURN)
                     || (op == ssbc_pkg::OP_INT) || (op == ssbc_pkg::OP_NONHALT);
  assign defer_br = ir0_reg[ssbc_pkg::F_WHEN] & ir0_reg[ssbc_pkg::F_PH_EN];
  assign take_now = cond_eval(ir0_reg, phase_lat_reg, first_byte_reg, carry_reg);
  assign take_def = cond_eval(ir0_reg, bf_reg.phase, bf_reg.data, carry_reg);
  assign take = (state_reg == ST_DEFER) ? take_def : take_now;
  assign br_fire = is_branch && (((state_reg == ST_EXEC) && !defer_br) || ((state_reg == ST_DEFER) && req_rise));
  assign dest = ir0_reg[ssbc_pkg::F_REL] ? ip_reg + {{8{ir1_reg[ssbc_pkg::F_OFS_HI]}},
                ir1_reg[ssbc_pkg::F_OFS_HI:0]} : ir1_reg;
  assign halt_now = br_fire && take && (op == ssbc_pkg::OP_INT);
  assign tgt = target_reg | ir0_reg[ssbc_pkg::F_TARGET];
  // io set means data flows toward the initiator
  assign send = tgt ? ph[ssbc_pkg::PH_IO] : !ph[ssbc_pkg::PH_IO];
  assign apb_wr = psel & penable & pwrite;
  assign irq_clr = apb_wr && (paddr == ssbc_pkg::A_CTRL) && pwdata[ssbc_pkg::C_IRQ_CLR];
  assign irq_set = (br_fire && take && ((op == ssbc_pkg::OP_INT) || (op == ssbc_pkg::OP_NONHALT)))
                   || ((state_reg == ST_DEFER) && is_move && req_rise && !take_def);

  // ----------------------------------------
  // interrupt flag
  // ----------------------------------------
  // a set in the same cycle as a clear is kept
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_set | (irq_reg & !irq_clr);
    end
  end

  // ----------------------------------------
  // sequencer, register file and bus drive
  // ----------------------------------------
  // apb writes sit first so the engine's own updates win
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_HALT;
      ip_reg <= ssbc_pkg::IP_RST;
      ir0_reg <= '0;
      ir1_reg <= '0;
      ir2_reg <= '0;
      intcode_reg <= '0;
      xaddr_reg <= '0;
      dst_reg <= '0;
      maddr_reg <= '0;
      for (int i = 0; i < 4; i++) begin
        gp_reg[i] <= '0;
      end
      xcnt_reg <= '0;
      byte_reg <= '0;
      first_byte_reg <= '0;
      phase_lat_reg <= '0;
      phase_drv_reg <= '0;
      carry_reg <= 1'b0;
      target_reg <= 1'b0;
      atn_reg <= 1'b0;
      ack_reg <= 1'b0;
      req_reg <= 1'b0;
      phase_oe_reg <= 1'b0;
      data_oe_reg <= 1'b0;
    end else begin
      if (apb_wr && (paddr[7:4] == ssbc_pkg::A_GP_PAGE)) begin
        gp_reg[paddr[3:2]] <= pwdata;
      end
      if (apb_wr && (state_reg == ST_HALT) && (paddr == ssbc_pkg::A_IP)) begin
        ip_reg <= pwdata;
      end
      if (apb_wr && (state_reg == ST_HALT) && (paddr == ssbc_pkg::A_CTRL) && pwdata[ssbc_pkg::C_START]) begin
        state_reg <= ST_F0;
        maddr_reg <= ip_reg;
      end
      // phase seen by the initiator is latched at each req
      if (req_rise && !target_reg) begin
        phase_lat_reg <= bf_reg.phase;
        first_byte_reg <= bf_reg.data;
      end
      unique case (state_reg)
        ST_HALT: begin
        end
        ST_F0: begin
          if (mem_i.ack) begin
            ir0_reg <= mem_i.rdata;
            maddr_reg <= ip_reg + ssbc_pkg::WORD_STEP;
            state_reg <= ST_F1;
          end
        end
        ST_F1: begin
          if (mem_i.ack) begin
            ir1_reg <= mem_i.rdata;
            if (ir0_reg[ssbc_pkg::F_OP_HI:ssbc_pkg::F_OP_LO] == ssbc_pkg::OP_MEMMOVE) begin
              maddr_reg <= maddr_reg + ssbc_pkg::WORD_STEP;
              state_reg <= ST_F2;
            end else begin
              ip_reg <= maddr_reg + ssbc_pkg::WORD_STEP;
              state_reg <= ST_EXEC;
            end
          end
        end
        ST_F2: begin
          if (mem_i.ack) begin
            ir2_reg <= mem_i.rdata;
            ip_reg <= maddr_reg + ssbc_pkg::WORD_STEP;
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state_reg <= ST_F0;
          maddr_reg <= ip_reg;
          if (ir0_reg[ssbc_pkg::F_TARGET]) begin
            target_reg <= 1'b1;
          end
          if (is_branch && defer_br) begin
            state_reg <= ST_DEFER;
          end
          if (is_move) begin
            if (ir0_reg[ssbc_pkg::F_TABLE]) begin
              maddr_reg <= gp_reg[ssbc_pkg::GP_TABLE] + ir1_reg;
              state_reg <= ST_TBL0;
            end else if (ir0_reg[ssbc_pkg::F_REL]) begin
              maddr_reg <= ir1_reg;
              xcnt_reg <= ir0_reg[ssbc_pkg::F_CNT_HI:0];
              state_reg <= ST_PTR;
            end else begin
              xcnt_reg <= ir0_reg[ssbc_pkg::F_CNT_HI:0];
              xaddr_reg <= ir1_reg;
              state_reg <= tgt ? ST_XPREP : ST_DEFER;
            end
          end
          if (op == ssbc_pkg::OP_MEMMOVE) begin
            xcnt_reg <= ir0_reg[ssbc_pkg::F_CNT_HI:0];
            xaddr_reg <= ir1_reg;
            dst_reg <= ir2_reg;
            maddr_reg <= ir1_reg;
            if (ir0_reg[ssbc_pkg::F_CNT_HI:0] != '0) begin
              state_reg <= ST_MMRD;
            end
          end
          if (op == ssbc_pkg::OP_WAIT_DISC) begin
            state_reg <= ST_WDISC;
          end
          if ((op == ssbc_pkg::OP_SET) || (op == ssbc_pkg::OP_CLEAR)) begin
            // only the flagged bits move
            if (ir0_reg[ssbc_pkg::F_SB_ATN]) begin
              atn_reg <= (op == ssbc_pkg::OP_SET);
            end
            if (ir0_reg[ssbc_pkg::F_SB_ACK]) begin
              ack_reg <= (op == ssbc_pkg::OP_SET);
            end
            if (ir0_reg[ssbc_pkg::F_SB_CARRY]) begin
              carry_reg <= (op == ssbc_pkg::OP_SET);
            end
          end
          if ((op == ssbc_pkg::OP_DISCONNECT) && target_reg) begin
            target_reg <= 1'b0;
            phase_oe_reg <= 1'b0;
            req_reg <= 1'b0;
            data_oe_reg <= 1'b0;
          end
          if (op == ssbc_pkg::OP_REGMOVE) begin
            gp_reg[ir0_reg[ssbc_pkg::F_RD_HI:0]] <= gp_reg[ir0_reg[ssbc_pkg::F_RS_HI:ssbc_pkg::F_RS_LO]];
          end
        end
        ST_DEFER: begin
          // moves: phase must match at the next req, else halt
          if (is_move && req_rise) begin
            state_reg <= take_def ? ST_XPREP : ST_HALT;
            maddr_reg <= xaddr_reg;
            if (!take_def) begin
              intcode_reg <= ssbc_pkg::PHASE_MISMATCH_CODE;
            end
          end
        end
        ST_TBL0: begin
          if (mem_i.ack) begin
            xcnt_reg <= mem_i.rdata[ssbc_pkg::F_CNT_HI:0];
            maddr_reg <= maddr_reg + ssbc_pkg::WORD_STEP;
            state_reg <= ST_TBL1;
          end
        end
        ST_TBL1, ST_PTR: begin
          if (mem_i.ack) begin
            xaddr_reg <= mem_i.rdata;
            maddr_reg <= mem_i.rdata;
            state_reg <= tgt ? ST_XPREP : ST_DEFER;
          end
        end
        ST_XPREP: begin
          if (tgt) begin
            phase_drv_reg <= ph;
            phase_oe_reg <= 1'b1;
          end
          maddr_reg <= xaddr_reg;
          if (xcnt_reg == '0) begin
            state_reg <= ST_F0;
            maddr_reg <= ip_reg;
          end else if (!send) begin
            state_reg <= ST_XSYNC;
          end else if (mem_i.ack) begin
            byte_reg <= mem_i.rdata[7:0];
            data_oe_reg <= 1'b1;
            state_reg <= ST_XSYNC;
          end
        end
        ST_XSYNC: begin
          if (tgt) begin
            req_reg <= 1'b1;
          end
          if (tgt ? bf_reg.ack : bf_reg.req) begin
            if (!send) begin
              byte_reg <= bf_reg.data;
              state_reg <= ST_XWR;
            end else begin
              req_reg <= 1'b0;
              ack_reg <= !tgt;
              state_reg <= ST_XDONE;
            end
          end
        end
        ST_XWR: begin
          if (mem_i.ack) begin
            req_reg <= 1'b0;
            ack_reg <= !tgt;
            state_reg <= ST_XDONE;
          end
        end
        ST_XDONE: begin
          if (!(tgt ? bf_reg.ack : bf_reg.req)) begin
            ack_reg <= 1'b0;
            data_oe_reg <= 1'b0;
            xcnt_reg <= xcnt_reg - 16'h0001;
            xaddr_reg <= xaddr_reg + 32'h0000_0001;
            maddr_reg <= xaddr_reg + 32'h0000_0001;
            state_reg <= ST_XPREP;
          end
        end
        ST_MMRD: begin
          if (mem_i.ack) begin
            byte_reg <= mem_i.rdata[7:0];
            maddr_reg <= dst_reg;
            state_reg <= ST_MMWR;
          end
        end
        ST_MMWR: begin
          if (mem_i.ack) begin
            xcnt_reg <= xcnt_reg - 16'h0001;
            xaddr_reg <= xaddr_reg + 32'h0000_0001;
            dst_reg <= dst_reg + 32'h0000_0001;
            maddr_reg <= xaddr_reg + 32'h0000_0001;
            state_reg <= ST_MMRD;
            if (xcnt_reg == 16'h0001) begin
              maddr_reg <= ip_reg;
              state_reg <= ST_F0;
            end
          end
        end
        ST_WDISC: begin
          if (!bf_reg.bsy) begin
            maddr_reg <= ip_reg;
            state_reg <= ST_F0;
          end
        end
      endcase
      // branch effects, immediate or deferred
      if (br_fire) begin
        state_reg <= halt_now ? ST_HALT : ST_F0;
        maddr_reg <= ip_reg;
        if (take) begin
          if ((op == ssbc_pkg::OP_JUMP) || (op == ssbc_pkg::OP_CALL)) begin
            ip_reg <= dest;
            maddr_reg <= dest;
          end
          if (op == ssbc_pkg::OP_CALL) begin
            gp_reg[ssbc_pkg::GP_RET] <= ip_reg;
          end
          if (op == ssbc_pkg::OP_RETURN) begin
            ip_reg <= gp_reg[ssbc_pkg::GP_RET];
            maddr_reg <= gp_reg[ssbc_pkg::GP_RET];
          end
          if (op == ssbc_pkg::OP_INT) begin
            intcode_reg <= ir1_reg;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  // zero wait states; read data captured in the setup cycle
  always_comb begin
    apb_hit = 1'b1;
    prdata_next = '0;
    if (paddr == ssbc_pkg::A_CTRL) begin
      prdata_next = {28'h000_0000, target_reg, carry_reg, irq_reg, state_reg != ST_HALT};
    end else if (paddr == ssbc_pkg::A_IP) begin
      prdata_next = ip_reg;
    end else if (paddr == ssbc_pkg::A_INTCODE) begin
      prdata_next = intcode_reg;
    end else if ((paddr[7:4] == ssbc_pkg::A_GP_PAGE) && (paddr[1:0] == 2'h0)) begin
      prdata_next = gp_reg[paddr[3:2]];
    end else begin
      apb_hit = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= prdata_next;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & !apb_hit;
  assign host_irq = irq_reg;

  // ----------------------------------------
  // memory and bus drive
  // ----------------------------------------
  assign mem_o.req = (state_reg == ST_F0) || (state_reg == ST_F1) || (state_reg == ST_F2)
                     || (state_reg == ST_TBL0) || (state_reg == ST_TBL1) || (state_reg == ST_PTR)
                     || ((state_reg == ST_XPREP) && send && (xcnt_reg != '0)) || (state_reg == ST_XWR)
                     || (state_reg == ST_MMRD) || (state_reg == ST_MMWR);
  assign mem_o.we = (state_reg == ST_XWR) || (state_reg == ST_MMWR);
  assign mem_o.addr = maddr_reg;
  assign mem_o.wdata = byte_reg;
  // atn, ack, req and bsy are open drain, driven only while asserted; phase and data follow their enables
  assign bus_o.atn = atn_reg;
  assign bus_o.ack = ack_reg;
  assign bus_o.req = req_reg;
  assign bus_o.bsy = target_reg;
  assign bus_o.phase = phase_drv_reg;
  assign bus_o.data = byte_reg;
  assign bus_o.atn_oe_n = !atn_reg;
  assign bus_o.ack_oe_n = !ack_reg;
  assign bus_o.req_oe_n = !req_reg;
  assign bus_o.bsy_oe_n = !target_reg;
  assign bus_o.phase_oe_n = !phase_oe_reg;
  assign bus_o.data_oe_n = !data_oe_reg;
endmodule : ssbc_sequencer

// ==== tb/ssbc_sequencer_asserts.sv ====
// ssbc_sequencer_asserts: port-level checks for the bus sequencer
// assumes: bound to ssbc_sequencer, one clock, rst async active high
`timescale 1ns/1ps
module ssbc_sequencer_asserts (
  input wire logic clk, // clock
  input wire logic rst, // async reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic pslverr, // apb error
  input wire ssbc_pkg::ssbc_mem_req_type mem_o, // memory request
  input wire ssbc_pkg::ssbc_mem_rsp_type mem_i, // memory answer
  input wire ssbc_pkg::ssbc_bus_out_type bus_o, // bus pins out
  input wire logic host_irq // host interrupt
);
  // ----------------
  // bus side checks
  // ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_access;
    psel && penable;
  endsequence
  // an enable that lags its value would glitch the shared line
  property p_atn_drive;
    bus_o.atn_oe_n == !bus_o.atn;
  endproperty
  a_atn_drive: assert property (p_atn_drive) else $error("atn enable disagrees");
  property p_ack_drive;
    bus_o.ack_oe_n == !bus_o.ack;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack enable disagrees");
  property p_bsy_drive;
    !bus_o.phase_oe_n |-> bus_o.bsy;
  endproperty
  a_bsy_drive: assert property (p_bsy_drive) else $error("phase driven without bsy");
  property p_req_drive;
    bus_o.req |-> !bus_o.phase_oe_n;
  endproperty
  a_req_drive: assert property (p_req_drive) else $error("req without phase drive");
  // ------------------
  // host side checks
  // ------------------
  property p_irq_hold;
    host_irq && !(psel && penable && pwrite && paddr == 8'h00 && pwdata[1]) |=> host_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without clear");
  property p_rst_idle;
    $fell(rst) |-> !host_irq && !mem_o.req;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
  property p_mem_hold;
    mem_o.req && !mem_i.ack |=> mem_o.req && $stable(mem_o.addr);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("fetch dropped before ack");
  property p_unmapped;
    s_access ##0 (paddr == 8'h0C) |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_err_only_access;
    pslverr |-> psel && penable;
  endproperty
  a_err_only_access: assert property (p_err_only_access) else $error("error outside access");
endmodule : ssbc_sequencer_asserts
bind ssbc_sequencer ssbc_sequencer_asserts u_chk (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pslverr(pslverr), .mem_o(mem_o), .mem_i(mem_i), .bus_o(bus_o), .host_irq(host_irq)
);

// ==== tb/ssbc_peer_model.sv ====
// ssbc_peer_model: host memory plus an idle bus peer
// assumes: byte addresses below 0x100, one ack pulse per access
`timescale 1ns/1ps
module ssbc_peer_model (
  input wire logic clk, // clock
  input wire logic rst, // async reset
  input wire ssbc_pkg::ssbc_mem_req_type mem_o, // request from sequencer
  output ssbc_pkg::ssbc_mem_rsp_type mem_i, // answer to sequencer
  output ssbc_pkg::ssbc_bus_in_type bus_i // bus pins toward sequencer
);
  logic [31:0] mem [64];
  logic [1:0] wait_reg;
  // ----------------
  // memory answers
  // ----------------
  // latency varies 0..2 so fetches never lean on a fixed delay
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_i <= '0;
      wait_reg <= '0;
    end else begin
      mem_i.ack <= 1'b0;
      mem_i.rdata <= ~mem_i.rdata; // no stale data between answers
      if (mem_o.req && !mem_i.ack) begin
        if (wait_reg != 2'h0) begin
          wait_reg <= wait_reg - 2'h1;
        end else begin
          mem_i.ack <= 1'b1;
          mem_i.rdata <= mem[mem_o.addr[7:2]] >> (8 * mem_o.addr[1:0]);
          if (mem_o.we) begin
            mem[mem_o.addr[7:2]][8 * mem_o.addr[1:0] +: 8] <= mem_o.wdata;
          end
          wait_reg <= 2'($urandom % 3);
        end
      end
    end
  end
  // no other device on the bus: lines rest low
  assign bus_i = '0;
endmodule : ssbc_peer_model

// ==== tb/tb.sv ====
// tb: self-checking bench for the sequencer, program run from memory
// assumes: peer model holds memory, apb master drives registers
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, code, code2;
  logic pready, pslverr, host_irq, slv;
  ssbc_pkg::ssbc_mem_req_type mem_o;
  ssbc_pkg::ssbc_mem_rsp_type mem_i;
  ssbc_pkg::ssbc_bus_in_type bus_i;
  ssbc_pkg::ssbc_bus_out_type bus_o;
  int err_count = 0;
  int n_compared = 0;
  int i;
  always #50 clk = ~clk;
  ssbc_sequencer DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_o(mem_o), .mem_i(mem_i),
    .bus_i(bus_i), .bus_o(bus_o), .host_irq(host_irq));
  ssbc_peer_model peer (.clk(clk), .rst(rst), .mem_o(mem_o), .mem_i(mem_i), .bus_i(bus_i));
  // ----------------
  // tasks
  // ----------------
  task finish_test;
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task check32(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check32
  // one apb transfer; request held until pready is seen at an edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 20) begin
      err_count++;
      finish_test;
    end
  endtask : apb
  task ld(input int a, input logic [31:0] w0, input logic [31:0] w1);
    peer.mem[a / 4] = w0;
    peer.mem[a / 4 + 1] = w1;
  endtask : ld
  // ----------------
  // main sequence
  // ----------------
  // wrong turns at 0x10 and 0x28 end in a halt with bad_code, so intcode exposes them
  initial begin
    void'($urandom(30939));
    code = $urandom;
    code2 = code ^ 32'h0000_00FF;
    ld(8'h00, 32'hA000_0005, 32'h0000_0000); // set carry and atn
    ld(8'h08, 32'h4090_0000, 32'h0000_0040); // jump if not carry
    ld(8'h10, 32'h4010_0000, 32'h0000_0020); // jump if carry
    ld(8'h18, 32'h7000_0000, 32'h0000_0BAD);
    ld(8'h20, 32'h5000_0000, 32'h0000_0050); // call
    ld(8'h28, 32'h4800_0000, 32'h0000_0008); // relative jump past 0x30
    ld(8'h30, 32'h7000_0000, 32'h0000_0BAD);
    ld(8'h38, 32'hD000_0301, 32'h0); // reg 3 to reg 1
    ld(8'h40, 32'h7000_0000, code); // halting interrupt
    ld(8'h50, 32'h8000_0000, code2); // non-halting interrupt
    ld(8'h58, 32'hB000_0004, 32'h0000_0000); // clear carry
    ld(8'h60, 32'h6000_0000, 32'h0000_0000); // return
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 8'h04, 32'h0); check32("ip reset", ssbc_pkg::IP_RST, rd);
    apb(1'b1, 8'h04, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_0001);
    i = 0;
    do begin
      apb(1'b0, 8'h00, 32'h0);
      i++;
    end while (rd[0] !== 1'b0 && i < 300);
    if (i >= 300) begin
      err_count++;
      finish_test;
    end
    apb(1'b0, 8'h08, 32'h0); check32("intcode", code, rd);
    apb(1'b0, 8'h1C, 32'h0); check32("return reg", 32'h0000_0028, rd);
    apb(1'b0, 8'h14, 32'h0); check32("reg move", 32'h0000_0028, rd);
    apb(1'b0, 8'h00, 32'h0); check32("ctrl", 32'h0000_0002, {28'h0, rd[3:0]});
    check32("atn pin", 32'h0000_0002, {30'h0, bus_o.atn, bus_o.atn_oe_n});
    apb(1'b1, 8'h00, 32'h0000_0002); check32("irq clear", 32'h0, {31'h0, host_irq});
    apb(1'b0, 8'h0C, 32'h0); check32("unmapped", 32'h1, {31'h0, slv});
    finish_test;
  end
endmodule : tb
